// File: src/mmn_pkg.sv
package mmn_pkg;

    // ************************************************************
    // Widths and fixed steps
    // ************************************************************
    localparam int          MMN_DW        = 32;
    localparam int          MMN_RW        = 4;
    localparam logic [31:0] MMN_PC_STEP   = 32'h0000_0002;
    localparam logic [31:0] MMN_LOAD_STEP = 32'h0000_0004;
    localparam int          MMN_PRIV_BIT  = 31;

    // ************************************************************
    // Patterns and masks
    // ************************************************************
    localparam logic [15:0] MMN_MSK_ONE   = 16'hF0FF;
    localparam logic [15:0] MMN_MSK_TWO   = 16'hF00F;
    localparam logic [15:0] MMN_MSK_ALL   = 16'hFFFF;
    localparam logic [15:0] MMN_ENC_CPFL  = 16'h0029;
    localparam logic [15:0] MMN_ENC_ULD   = 16'h40A9;
    localparam logic [15:0] MMN_ENC_ULDI  = 16'h40E9;
    localparam logic [15:0] MMN_ENC_LMUL  = 16'h0007;
    localparam logic [15:0] MMN_ENC_SMUL  = 16'h200F;
    localparam logic [15:0] MMN_ENC_UMUL  = 16'h200E;
    localparam logic [15:0] MMN_ENC_NEG   = 16'h600B;
    localparam logic [15:0] MMN_ENC_NEGB  = 16'h600A;
    localparam logic [15:0] MMN_ENC_NOP   = 16'h0009;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  MMN_OFS_STATUS = 8'h00;
    localparam logic [7:0]  MMN_OFS_MASK   = 8'h04;
    localparam logic [7:0]  MMN_OFS_CTRL   = 8'h08;
    localparam logic [7:0]  MMN_OFS_MULLO  = 8'h0C;
    localparam int          MMN_ST_W       = 5;
    localparam int          MMN_ST_ADDR    = 0;
    localparam int          MMN_ST_TLBMH   = 1;
    localparam int          MMN_ST_TLBMISS = 2;
    localparam int          MMN_ST_TLBPROT = 3;
    localparam int          MMN_ST_DONE    = 4;
    localparam int          MMN_CTL_PRIV   = 0;
    localparam logic [4:0]  MMN_RST_STATUS = 5'h00;
    localparam logic [4:0]  MMN_RST_MASK   = 5'h00;
    localparam logic        MMN_RST_CTRL   = 1'b1;

    // ************************************************************
    // Exception codes
    // ************************************************************
    localparam logic [1:0]  MMN_EXC_ADDR    = 2'h0;
    localparam logic [1:0]  MMN_EXC_TLBMH   = 2'h1;
    localparam logic [1:0]  MMN_EXC_TLBMISS = 2'h2;
    localparam logic [1:0]  MMN_EXC_TLBPROT = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum {
        OP_NONE, OP_CPFL, OP_ULD, OP_ULDI, OP_LMUL,
        OP_SMUL, OP_UMUL, OP_NEG, OP_NEGB, OP_NOP
    } mmn_op_t;

    typedef enum {ST_IDLE, ST_LMUL, ST_LOAD} mmn_state_t;

endpackage

// File: src/mmn_decode.sv
`timescale 1ns/1ps
module mmn_decode
    import mmn_pkg::*;
(
    input  wire logic [15:0] i_instr,  // Instruction word
    output mmn_op_t          o_op      // Decoded operation
);

    // ************************************************************
    // Pattern matches
    // ************************************************************
    wire hit_cpfl = (i_instr & MMN_MSK_ONE) == MMN_ENC_CPFL;
    wire hit_uld  = (i_instr & MMN_MSK_ONE) == MMN_ENC_ULD;
    wire hit_uldi = (i_instr & MMN_MSK_ONE) == MMN_ENC_ULDI;
    wire hit_lmul = (i_instr & MMN_MSK_TWO) == MMN_ENC_LMUL;
    wire hit_smul = (i_instr & MMN_MSK_TWO) == MMN_ENC_SMUL;
    wire hit_umul = (i_instr & MMN_MSK_TWO) == MMN_ENC_UMUL;
    wire hit_neg  = (i_instr & MMN_MSK_TWO) == MMN_ENC_NEG;
    wire hit_negb = (i_instr & MMN_MSK_TWO) == MMN_ENC_NEGB;
    wire hit_nop  = (i_instr & MMN_MSK_ALL) == MMN_ENC_NOP;

    // Priority select
    assign o_op = hit_nop  ? OP_NOP  :
                  hit_cpfl ? OP_CPFL :
                  hit_uld  ? OP_ULD  :
                  hit_uldi ? OP_ULDI :
                  hit_lmul ? OP_LMUL :
                  hit_smul ? OP_SMUL :
                  hit_umul ? OP_UMUL :
                  hit_neg  ? OP_NEG  :
                  hit_negb ? OP_NEGB : OP_NONE;

endmodule // mmn_decode

// File: src/mmn_mul.sv
`timescale 1ns/1ps
module mmn_mul
    import mmn_pkg::*;
#(
    parameter int DW = MMN_DW
) (
    input  wire logic [DW-1:0] i_a,       // Operand from field n
    input  wire logic [DW-1:0] i_b,       // Operand from field m
    input  wire logic          i_word,    // Use low 16 bits only
    input  wire logic          i_signed,  // Word operands signed
    output logic      [DW-1:0] o_prod     // Low half of product
);

    // ************************************************************
    // Word operand extension
    // ************************************************************
    wire        ext_a = i_signed & i_a[15];
    wire        ext_b = i_signed & i_b[15];
    wire [31:0] wa    = {{16{ext_a}}, i_a[15:0]};
    wire [31:0] wb    = {{16{ext_b}}, i_b[15:0]};

    // Low product half
    wire [63:0] full_long = 64'(i_a) * 64'(i_b);
    wire [63:0] full_word = 64'(wa) * 64'(wb);

    assign o_prod = i_word ? full_word[DW-1:0] : full_long[DW-1:0];

endmodule // mmn_mul

// File: src/mmn_exec.sv
// Function
// - Copy flag into register n as 32-bit one or zero, one cycle.
// - Unaligned load from address in register n into register zero.
// - Post-increment form adds four to n unless n is register zero.
// - No misalignment error for any load byte offset.
// - Address error only for user access to privileged region.
// - Load reports translation multi-hit, miss and protection faults.
// - Long multiply writes low 32 product bits to result low, two cycles.
// - Multiplies never touch the high result register.
// - Signed word multiply of low halves into result low, one cycle.
// - Unsigned word multiply of low halves into result low, one cycle.
// - Negate writes zero minus m into n; flag unchanged.
// - Negate with borrow writes zero minus m minus flag into n.
// - Flag after negate with borrow is set when either step borrows.
// - No-operation changes nothing but the program counter and the done status bit.
`timescale 1ns/1ps
module mmn_exec
    import mmn_pkg::*;
#(
    parameter int DW = MMN_DW
) (
    input  wire logic          i_clk_sys,    // Core clock
    input  wire logic          i_arst_n,     // Async reset, low
    // Issue from decoder and register file
    input  wire logic          i_issue,      // Instruction offered
    input  wire logic [15:0]   i_instr,      // Instruction word
    input  wire logic [DW-1:0] i_val_n,      // Reg field 11:8
    input  wire logic [DW-1:0] i_val_m,      // Reg field 7:4
    input  wire logic [DW-1:0] i_pc,         // Address of instruction
    input  wire logic          i_flag,       // Condition flag
    input  wire logic          i_user,       // User mode
    output logic               o_busy,       // Not accepting issue
    // Register file writes
    output logic               o_gpr_we,     // Main write strobe
    output logic [MMN_RW-1:0]  o_gpr_waddr,  // Main write index
    output logic [DW-1:0]      o_gpr_wdata,  // Main write data
    output logic               o_inc_we,     // Pointer write strobe
    output logic [MMN_RW-1:0]  o_inc_waddr,  // Pointer write index
    output logic [DW-1:0]      o_inc_wdata,  // Pointer write data
    output logic               o_flag_we,    // Flag write strobe
    output logic               o_flag,       // New flag value
    output logic               o_pc_we,      // Counter write strobe
    output logic [DW-1:0]      o_pc,         // New counter value
    output logic [DW-1:0]      o_mul_lo,     // Multiply result low
    // Operand memory path
    output logic               o_mem_req,    // Longword read request
    output logic [DW-1:0]      o_mem_addr,   // Byte address
    input  wire logic          i_mem_ack,    // Read answered
    input  wire logic [DW-1:0] i_mem_rdata,  // Read data
    input  wire logic          i_mem_tlbmh,  // TLB multi-hit
    input  wire logic          i_mem_tlbmiss,// TLB miss
    input  wire logic          i_mem_tlbprot,// TLB protection
    output logic               o_exc,        // Exception pulse
    output logic [1:0]         o_exc_code,   // Exception kind
    // Register port
    input  wire logic [7:0]    i_reg_addr,   // Byte offset
    input  wire logic [31:0]   i_reg_wdata,  // Write data
    input  wire logic          i_reg_wr,     // Write strobe
    input  wire logic          i_reg_rd,     // Read strobe
    output logic [31:0]        o_reg_rdata,  // Read data, next cycle
    output logic               o_irq         // Interrupt level
);

    // ************************************************************
    // Decode and arithmetic
    // ************************************************************
    mmn_op_t    op;
    mmn_state_t state_ff, nxt_state;

    mmn_decode u_dec (
        .i_instr (i_instr),
        .o_op    (op)
    );

    wire [DW-1:0] prod;
    wire          word_mul = (op == OP_SMUL) || (op == OP_UMUL);

    mmn_mul #(.DW(DW)) u_mul (
        .i_a      (i_val_n),
        .i_b      (i_val_m),
        .i_word   (word_mul),
        .i_signed (op == OP_SMUL),
        .o_prod   (prod)
    );

    // Negate paths
    wire [DW-1:0] neg_m    = DW'(0) - i_val_m;
    wire [DW-1:0] negb_res = neg_m - DW'(i_flag);
    wire          negb_bor = (neg_m != '0) || (neg_m < negb_res);

    // ************************************************************
    // Issue and load checks
    // ************************************************************
    logic            ctrl_priv_ff;
    logic [DW-1:0]   pc_hold_ff;
    logic [DW-1:0]   lmul_ff;
    logic [MMN_RW-1:0] ld_reg_ff;
    logic            ld_inc_ff;

    wire take      = i_issue && (state_ff == ST_IDLE);
    wire is_load   = (op == OP_ULD) || (op == OP_ULDI);
    wire [MMN_RW-1:0] fld_n = i_instr[11:8];
    // Only privilege is checked; low address bits never fault
    wire priv_err  = ctrl_priv_ff && i_user
                   && i_val_n[MMN_PRIV_BIT];
    wire ack_fault = i_mem_tlbmh || i_mem_tlbmiss || i_mem_tlbprot;
    wire ld_ack    = (state_ff == ST_LOAD) && i_mem_ack;
    wire [1:0] tlb_code = i_mem_tlbmh   ? MMN_EXC_TLBMH   :
                          i_mem_tlbmiss ? MMN_EXC_TLBMISS :
                                          MMN_EXC_TLBPROT;
    wire pc_src_hold = (state_ff != ST_IDLE);
    wire [DW-1:0] pc_next = (pc_src_hold ? pc_hold_ff : i_pc)
                          + MMN_PC_STEP;

    // ************************************************************
    // Next values
    // ************************************************************
    logic              nxt_gpr_we, nxt_inc_we, nxt_flag_we, nxt_pc_we;
    logic [MMN_RW-1:0] nxt_gpr_waddr, nxt_inc_waddr;
    logic [DW-1:0]     nxt_gpr_wdata, nxt_inc_wdata, nxt_mul_lo;
    logic              nxt_flag, nxt_mem_req, nxt_exc;
    logic [1:0]        nxt_exc_code;

    always_comb begin
        nxt_state     = state_ff;
        nxt_gpr_we    = 1'b0;
        nxt_gpr_waddr = fld_n;
        nxt_gpr_wdata = '0;
        nxt_inc_we    = 1'b0;
        nxt_inc_waddr = ld_reg_ff;
        nxt_inc_wdata = o_mem_addr + MMN_LOAD_STEP;
        nxt_flag_we   = 1'b0;
        nxt_flag      = i_flag;
        nxt_pc_we     = 1'b0;
        nxt_mul_lo    = o_mul_lo;
        nxt_mem_req   = 1'b0;
        nxt_exc       = 1'b0;
        nxt_exc_code  = o_exc_code;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_pc_we = (op != OP_NONE) && !is_load
                              && (op != OP_LMUL);
                    case (op)
                        OP_CPFL: begin
                            nxt_gpr_we    = 1'b1;
                            nxt_gpr_wdata = DW'(i_flag);
                        end
                        OP_ULD, OP_ULDI: begin
                            if (priv_err) begin
                                nxt_exc      = 1'b1;
                                nxt_exc_code = MMN_EXC_ADDR;
                            end else begin
                                nxt_mem_req = 1'b1;
                                nxt_state   = ST_LOAD;
                            end
                        end
                        OP_LMUL: begin
                            nxt_state = ST_LMUL;
                        end
                        OP_SMUL, OP_UMUL: begin
                            nxt_mul_lo = prod;
                        end
                        OP_NEG: begin
                            nxt_gpr_we    = 1'b1;
                            nxt_gpr_wdata = neg_m;
                        end
                        OP_NEGB: begin
                            nxt_gpr_we    = 1'b1;
                            nxt_gpr_wdata = negb_res;
                            nxt_flag_we   = 1'b1;
                            nxt_flag      = negb_bor;
                        end
                        OP_NOP: begin
                            nxt_pc_we = 1'b1;
                        end
                        default: begin
                            nxt_pc_we = 1'b0;
                        end
                    endcase
                end
            end
            ST_LMUL: begin
                nxt_mul_lo = lmul_ff;
                nxt_pc_we  = 1'b1;
                nxt_state  = ST_IDLE;
            end
            ST_LOAD: begin
                if (ld_ack) begin
                    nxt_state = ST_IDLE;
                    if (ack_fault) begin
                        nxt_exc      = 1'b1;
                        nxt_exc_code = tlb_code;
                    end else begin
                        nxt_gpr_we    = 1'b1;
                        nxt_gpr_waddr = '0;
                        nxt_gpr_wdata = i_mem_rdata;
                        nxt_inc_we    = ld_inc_ff
                                      && (ld_reg_ff != '0);
                        nxt_pc_we     = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Result registers
    // ************************************************************
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_ff    <= ST_IDLE;
            o_gpr_we    <= 1'b0;
            o_gpr_waddr <= '0;
            o_gpr_wdata <= '0;
            o_inc_we    <= 1'b0;
            o_inc_waddr <= '0;
            o_inc_wdata <= '0;
            o_flag_we   <= 1'b0;
            o_flag      <= 1'b0;
            o_pc_we     <= 1'b0;
            o_pc        <= '0;
            o_mul_lo    <= '0;
            o_mem_req   <= 1'b0;
            o_exc       <= 1'b0;
            o_exc_code  <= MMN_EXC_ADDR;
        end else begin
            state_ff    <= nxt_state;
            o_gpr_we    <= nxt_gpr_we;
            o_gpr_waddr <= nxt_gpr_waddr;
            o_gpr_wdata <= nxt_gpr_wdata;
            o_inc_we    <= nxt_inc_we;
            o_inc_waddr <= nxt_inc_waddr;
            o_inc_wdata <= nxt_inc_wdata;
            o_flag_we   <= nxt_flag_we;
            o_flag      <= nxt_flag;
            o_pc_we     <= nxt_pc_we;
            o_pc        <= pc_next;
            o_mul_lo    <= nxt_mul_lo;
            o_mem_req   <= nxt_mem_req;
            o_exc       <= nxt_exc;
            o_exc_code  <= nxt_exc_code;
        end
    end

    // Operands held for multi-cycle work
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pc_hold_ff <= '0;
            lmul_ff    <= '0;
            ld_reg_ff  <= '0;
            ld_inc_ff  <= 1'b0;
            o_mem_addr <= '0;
        end else if (take) begin
            pc_hold_ff <= i_pc;
            lmul_ff    <= prod;
            ld_reg_ff  <= fld_n;
            ld_inc_ff  <= (op == OP_ULDI);
            o_mem_addr <= i_val_n;
        end
    end

    // Busy while work pending
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (nxt_state != ST_IDLE);
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    logic [MMN_ST_W-1:0] status_ff, mask_ff;

    wire wr_status = i_reg_wr && (i_reg_addr == MMN_OFS_STATUS);
    wire wr_mask   = i_reg_wr && (i_reg_addr == MMN_OFS_MASK);
    wire wr_ctrl   = i_reg_wr && (i_reg_addr == MMN_OFS_CTRL);
    wire done_evt  = nxt_pc_we;

    // Event bits; a new event wins over a one-to-clear write
    wire [MMN_ST_W-1:0] evt;
    assign evt[MMN_ST_ADDR]    = nxt_exc && (nxt_exc_code == MMN_EXC_ADDR);
    assign evt[MMN_ST_TLBMH]   = nxt_exc && (nxt_exc_code == MMN_EXC_TLBMH);
    assign evt[MMN_ST_TLBMISS] = nxt_exc
                               && (nxt_exc_code == MMN_EXC_TLBMISS);
    assign evt[MMN_ST_TLBPROT] = nxt_exc
                               && (nxt_exc_code == MMN_EXC_TLBPROT);
    assign evt[MMN_ST_DONE]    = done_evt;

    wire [MMN_ST_W-1:0] clr = wr_status ? i_reg_wdata[MMN_ST_W-1:0] : '0;
    wire [MMN_ST_W-1:0] nxt_status = (status_ff & ~clr) | evt;

    wire [31:0] rd_mux =
        (i_reg_addr == MMN_OFS_STATUS) ? 32'(status_ff)    :
        (i_reg_addr == MMN_OFS_MASK)   ? 32'(mask_ff)      :
        (i_reg_addr == MMN_OFS_CTRL)   ? 32'(ctrl_priv_ff) :
        (i_reg_addr == MMN_OFS_MULLO)  ? 32'(o_mul_lo)     : 32'h0000_0000;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            status_ff    <= MMN_RST_STATUS;
            mask_ff      <= MMN_RST_MASK;
            ctrl_priv_ff <= MMN_RST_CTRL;
            o_reg_rdata  <= 32'h0000_0000;
            o_irq        <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            if (wr_mask) begin
                mask_ff <= i_reg_wdata[MMN_ST_W-1:0];
            end
            if (wr_ctrl) begin
                ctrl_priv_ff <= i_reg_wdata[MMN_CTL_PRIV];
            end
            o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
            o_irq       <= |(nxt_status & mask_ff);
        end
    end

endmodule // mmn_exec

// File: verification/mmn_exec_asserts.sv
`timescale 1ns/1ps
module mmn_exec_asserts
    import mmn_pkg::*;
#(
    parameter int DW = MMN_DW
) (
    input wire logic          i_clk_sys, i_arst_n,   // Clock, reset
    input wire logic          i_issue, i_flag,       // Issue, flag
    input wire logic          i_user, i_mem_ack,     // Mode, ack
    input wire logic [15:0]   i_instr,               // Instruction
    input wire logic [DW-1:0] i_val_n, i_val_m,      // Operands
    input wire logic [DW-1:0] i_pc, i_mem_rdata,     // Counter, data
    input wire logic          o_busy, o_gpr_we,      // Busy, write
    input wire logic          o_flag_we, o_flag,     // Flag write
    input wire logic          o_pc_we, o_mem_req,    // Counter, request
    input wire logic          o_exc,                 // Exception
    input wire logic [3:0]    o_gpr_waddr,           // Write index
    input wire logic [DW-1:0] o_gpr_wdata, o_pc,     // Write data
    input wire logic [DW-1:0] o_mul_lo, o_mem_addr   // Product, address
);
    // Taken issue, masked words
    wire        tk = i_issue && !o_busy;
    wire [15:0] w1 = i_instr & MMN_MSK_ONE;
    wire [15:0] w2 = i_instr & MMN_MSK_TWO;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    a_flag_copy: assert property (tk && w1 == MMN_ENC_CPFL |=> o_gpr_we
        && o_gpr_wdata == {31'h0, $past(i_flag)} && !o_flag_we)
        else $error("flag copy wrong");
    a_borrow_flag: assert property (tk && w2 == MMN_ENC_NEGB |=> o_flag_we
        && o_flag == ($past(i_val_m) != 0 || $past(i_flag))
        && o_gpr_wdata == 32'h0 - $past(i_val_m) - $past(i_flag))
        else $error("borrow negate wrong");
    a_long_two: assert property (tk && w2 == MMN_ENC_LMUL |=> !o_pc_we
        ##1 o_pc_we && o_mul_lo == $past(i_val_n, 2) * $past(i_val_m, 2))
        else $error("long multiply wrong");
    a_word_mul: assert property (tk && w2 == MMN_ENC_UMUL |=> o_pc_we
        && o_mul_lo == $past(i_val_n[15:0]) * $past(i_val_m[15:0]))
        else $error("unsigned multiply wrong");
    a_nop_quiet: assert property (tk && i_instr == MMN_ENC_NOP |=> o_pc_we
        && !o_gpr_we && !o_flag_we && o_pc == $past(i_pc) + MMN_PC_STEP)
        else $error("no-operation wrong");
    a_load_issue: assert property (tk && !i_user && (w1 == MMN_ENC_ULD
        || w1 == MMN_ENC_ULDI) |=> o_mem_req && !o_exc
        && o_mem_addr == $past(i_val_n))
        else $error("load request wrong");
    a_load_data: assert property (i_mem_ack && o_busy |=> o_exc ||
        o_gpr_we && o_gpr_waddr == 4'h0 && o_gpr_wdata == $past(i_mem_rdata))
        else $error("load data wrong");
    a_fault_quiet: assert property (o_exc |-> !o_gpr_we && !o_pc_we)
        else $error("write beside exception");

    c_long: cover property (tk && w2 == MMN_ENC_LMUL);
    c_ack: cover property (i_mem_ack && o_busy);
    c_exc: cover property (o_exc);
endmodule // mmn_exec_asserts

bind mmn_exec mmn_exec_asserts #(.DW(DW)) u_chk (.*);

// File: verification/mmn_mem_model.sv
`timescale 1ns/1ps
module mmn_mem_model (
    input  wire logic        i_clk,    // Core clock
    input  wire logic        i_req,    // Read request
    input  wire logic [31:0] i_addr,   // Byte address
    input  wire logic [3:0]  i_dly,    // Answer delay
    input  wire logic [2:0]  i_flt,    // Faults to report
    output logic             o_ack,    // Answer pulse
    output logic [31:0]      o_rdata,  // Data, toggles when idle
    output logic [2:0]       o_flt     // Faults with answer
);
    logic [3:0] cnt_ff = 4'h0;
    logic       pend_ff = 1'b0;

    // Answer after the delay
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_flt <= 3'h0;
        o_rdata <= ~o_rdata;
        if (i_req) begin
            pend_ff <= 1'b1;
            cnt_ff <= i_dly;
        end else if (pend_ff && cnt_ff == 4'h0) begin
            pend_ff <= 1'b0;
            o_ack <= 1'b1;
            o_flt <= i_flt;
            o_rdata <= i_addr ^ 32'hA5A5_5A5A;
        end else if (pend_ff)
            cnt_ff <= cnt_ff - 4'h1;
    end
    initial o_rdata = 32'h0;
endmodule // mmn_mem_model

// File: verification/test_move_multiply_negate_exec.sv
`timescale 1ns/1ps
module test_move_multiply_negate_exec;
    import mmn_pkg::*;
    logic        i_clk_sys = 0, i_arst_n = 0, i_issue = 0, i_flag = 0;
    logic        i_user = 0, i_reg_wr = 0, i_reg_rd = 0, i_mem_ack;
    logic [15:0] i_instr = '0;
    logic [31:0] i_val_n = '0, i_val_m = '0, i_pc = 32'h0000_1000;
    logic [31:0] i_reg_wdata = '0, i_mem_rdata, o_gpr_wdata, o_inc_wdata;
    logic [31:0] o_pc, o_mul_lo, o_mem_addr, o_reg_rdata;
    logic [7:0]  i_reg_addr = '0;
    logic [3:0]  o_gpr_waddr, o_inc_waddr, dly = '0;
    logic [2:0]  flt = '0;
    logic [1:0]  o_exc_code;
    logic        i_mem_tlbmh, i_mem_tlbmiss, i_mem_tlbprot, o_busy, o_gpr_we;
    logic        o_inc_we, o_flag_we, o_flag, o_pc_we, o_mem_req, o_exc, o_irq;
    int          err_count = 0, compares = 0, cyc = 0;

    mmn_exec dut (.*);
    mmn_mem_model mem (.i_clk(i_clk_sys), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .i_dly(dly), .i_flt(flt), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata),
        .o_flt({i_mem_tlbprot, i_mem_tlbmiss, i_mem_tlbmh}));

    // Clock and hang guard
    always #2 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (++cyc == 3000) begin
        err_count++;
        $display("Error %0t timeout", $time);
        print_verdict();
    end

    task print_verdict();
        $display("Compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] g, e, input string s);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t %s", $time, s);
        end
    endtask

    // Issue one instruction
    task run(input logic [15:0] c, input logic [31:0] n, m,
             input logic f);
        @(posedge i_clk_sys);
        i_instr <= c;
        i_val_n <= n;
        i_val_m <= m;
        i_flag <= f;
        i_issue <= 1'b1;
        @(posedge i_clk_sys);
        i_issue <= 1'b0;
        #1;
    endtask

    task wait_end();
        for (int k = 0; k < 20 && !(o_gpr_we || o_exc); k++) begin
            @(posedge i_clk_sys);
            #1;
        end
    endtask

    task reg_io(input logic [7:0] a, input logic w,
                input logic [31:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= w;
        i_reg_rd <= !w;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        #1;
    endtask

    task t_alu();
        logic [31:0] mv;
        for (int f = 0; f < 2; f++) begin
            run(16'h0529, 32'hFFFF_FFFF, '0, f[0]);
            chk(o_gpr_wdata, f, "flag copy");
            chk({o_gpr_waddr, o_flag_we}, 5'h0A, "copy dest");
            chk(o_pc, i_pc + 32'h2, "pc step");
        end
        run(16'h631B, '0, 32'h1, 1'b1);
        chk(o_gpr_wdata, 32'hFFFF_FFFF, "neg");
        chk({o_gpr_waddr, o_flag_we}, 5'h06, "neg dest");
        for (int k = 0; k < 4; k++) begin
            mv = 32'(k == 0) | {32{k == 3}};
            run(16'h620A, '0, mv, k[0]);
            chk(o_gpr_wdata, 32'h0 - mv - k[0], "nb value");
            chk({o_flag_we, o_flag}, {1'b1, mv != 0 || k[0]}, "borrow");
        end
        run(16'h0009, '0, '0, 1'b0);
        chk({o_pc_we, o_gpr_we, o_flag_we, o_mem_req}, 4'h8, "nop");
        $display("Test alu done");
    endtask

    task t_mul();
        run(16'h200E, 32'hFFFF_AAAA, 32'h2, 1'b0);
        chk(o_mul_lo, 32'h0001_5554, "uprod");
        run(16'h200F, 32'h5555, 32'hFFFF_FFFE, 1'b0);
        chk(o_mul_lo, 32'hFFFF_5556, "sprod");
        run(16'h0007, 32'h5555, 32'h8000_FFFE, 1'b0);
        chk({o_busy, o_pc_we}, 2'b10, "long wait");
        @(posedge i_clk_sys);
        #1;
        chk(o_mul_lo, 32'h5555 * 32'h8000_FFFE, "lprod");
        chk({o_busy, o_pc_we}, 2'b01, "long done");
        $display("Test multiply done");
    endtask

    task t_load();
        dly <= 4'h2;
        run(16'h41E9, 32'h0000_1007, '0, 1'b0);
        chk(o_mem_addr, 32'h1007, "addr");
        wait_end();
        chk(o_gpr_wdata, 32'h1007 ^ 32'hA5A5_5A5A, "load data");
        chk({o_inc_we, o_inc_waddr, o_gpr_waddr}, 9'h110, "inc dest");
        chk(o_inc_wdata, 32'h100B, "inc value");
        dly <= 4'h0;
        run(16'h40E9, 32'h1001, '0, 1'b0);
        wait_end();
        chk(o_inc_we, 0, "no inc");
        for (int k = 0; k < 3; k++) begin
            flt <= 3'h1 << k;
            run(16'h40A9, 32'h2002, '0, 1'b0);
            wait_end();
            chk({o_exc, o_exc_code, o_gpr_we, o_pc_we}, {1'b1, 2'(k + 1), 2'b00}, "fault");
        end
        flt <= 3'h0;
        i_user <= 1'b1;
        run(16'h40A9, 32'h8000_0001, '0, 1'b0);
        chk({o_exc, o_exc_code, o_mem_req}, 4'h8, "priv");
        run(16'h40A9, 32'h0000_0003, '0, 1'b0);
        chk({o_exc, o_mem_req}, 2'b01, "user load");
        wait_end();
        chk(o_gpr_we, 1, "user data");
        i_user <= 1'b0;
        $display("Test load done");
    endtask

    task t_irq();
        reg_io(MMN_OFS_CTRL, 1'b0, '0);
        chk(o_reg_rdata, 1, "ctrl");
        reg_io(8'h10, 1'b0, '0);
        chk(o_reg_rdata, 0, "unmapped");
        reg_io(MMN_OFS_STATUS, 1'b1, 32'h1F);
        reg_io(MMN_OFS_MASK, 1'b1, 32'h10);
        run(16'h0009, '0, '0, 1'b0);
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(o_irq, 1, "irq on");
        reg_io(MMN_OFS_MASK, 1'b1, 32'h0);
        @(posedge i_clk_sys);
        #1;
        chk(o_irq, 0, "irq off");
        reg_io(MMN_OFS_STATUS, 1'b0, '0);
        chk(o_reg_rdata, 32'h10, "status");
        reg_io(MMN_OFS_STATUS, 1'b1, 32'h10);
        reg_io(MMN_OFS_STATUS, 1'b0, '0);
        chk(o_reg_rdata, 0, "cleared");
        $display("Test irq done");
    endtask

    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        t_alu();
        t_mul();
        t_load();
        t_irq();
        print_verdict();
    end
endmodule // test_move_multiply_negate_exec
